// [rtl/dmaac_map.vh]
// Register indices, field positions, codes and reset values of the DMA address/count block.
// Assumes a byte-addressed register port with word-aligned registers, 0x20 bytes of address space per channel.
`ifndef DMAAC_MAP_VH
`define DMAAC_MAP_VH

`define DMAAC_ADDR_W     8
`define DMAAC_CH_STRIDE  8'h20

`define DMAAC_IDX_SRC    3'h0
`define DMAAC_IDX_DST    3'h1
`define DMAAC_IDX_OFS    3'h2
`define DMAAC_IDX_CNT    3'h3
`define DMAAC_IDX_CTL    3'h4
`define DMAAC_IDX_STS    3'h5

`define DMAAC_CTL_W      10
`define DMAAC_CTL_EN     0
`define DMAAC_CTL_SGL    1
`define DMAAC_CTL_DIR    2
`define DMAAC_CTL_AUTO   3
`define DMAAC_CTL_SZ     5:4
`define DMAAC_CTL_SM     7:6
`define DMAAC_CTL_DM     9:8

`define DMAAC_STS_EN     0
`define DMAAC_STS_DONE   1
`define DMAAC_STS_BUSY   2

`define DMAAC_SZ_BYTE    2'h0
`define DMAAC_SZ_WORD    2'h1
`define DMAAC_SZ_LONG    2'h2

`define DMAAC_AM_FIX     2'h0
`define DMAAC_AM_OFS     2'h1
`define DMAAC_AM_INC     2'h2
`define DMAAC_AM_DEC     2'h3

`define DMAAC_REG_RST    32'h00000000
`define DMAAC_CTL_RST    10'h000
`define DMAAC_CNT_FREE   32'h00000000
`define DMAAC_GAP_CYC    2'h2

`endif

// [rtl/dmaac_sync.v]
// Two-stage synchroniser for request pins.
// Assumes inputs are asynchronous levels; outputs are two clocks late.
`timescale 1ns/1ps
module dmaac_sync #(
  parameter W = 4
) (
  input  wire         clk,    // System clock
  input  wire         rst_n,  // Synchronous reset, active low
  input  wire [W-1:0] d_in,   // Asynchronous inputs
  output wire [W-1:0] d_out   // Synchronised outputs
);
  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  always @(posedge clk) begin
    if (!rst_n) begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end else begin
      meta_r <= d_in;
      sync_r <= meta_r;
    end
  end

  assign d_out = sync_r;
endmodule // dmaac_sync

// [rtl/dmaac_addr_step.v]
// Next-address calculation for one address register.
// Assumes step is the access size in bytes (1, 2 or 4); wraps modulo 2^32.
`timescale 1ns/1ps
`include "dmaac_map.vh"
module dmaac_addr_step (
  input  wire [31:0] addr,    // Current address
  input  wire [31:0] offset,  // Programmed step offset
  input  wire [1:0]  mode,    // Update mode code
  input  wire [2:0]  step,    // Access size in bytes
  output reg  [31:0] next     // Address after one item
);
  always @* begin
    case (mode)
      `DMAAC_AM_FIX: next = addr;
      `DMAAC_AM_OFS: next = addr + offset;
      `DMAAC_AM_INC: next = addr + {29'h0, step};
      `DMAAC_AM_DEC: next = addr - {29'h0, step};
      default:       next = addr;
    endcase
  end
endmodule // dmaac_addr_step

// [rtl/dmaac_top.v]
// Four-channel DMA address and count datapath with register port and peripheral handshake.
// Assumes a bus engine that moves one data item per bus_valid and answers with a bus_done pulse.
// Assumes software keeps its hands off a channel's registers while that channel runs.
// Request pins may change at any time; they are synchronised inside.
`timescale 1ns/1ps
`include "dmaac_map.vh"
module dmaac_top #(
  parameter NCH = 4
) (
  input  wire                     clk,                  // System clock, 125 MHz
  input  wire                     rst_n,                // Synchronous reset, active low
  input  wire [`DMAAC_ADDR_W-1:0] reg_addr,             // Register byte address
  input  wire [31:0]              reg_wdata,            // Register write data
  input  wire                     reg_wr,               // Write strobe
  input  wire                     reg_rd,               // Read strobe
  output reg  [31:0]              reg_rdata,            // Read data, cycle after reg_rd
  input  wire [NCH-1:0]           xfer_req_in,          // Peripheral transfer requests, active high
  output reg  [NCH-1:0]           single_addr_ack_out,  // Single-address acknowledge per channel
  output reg  [NCH-1:0]           xfer_end_out,         // High during a channel's final item
  output reg  [NCH-1:0]           xfer_end_irq,         // Sticky transfer-end request to the CPU
  output reg                      bus_valid,            // One item pending for the bus engine
  output reg  [1:0]               bus_chan,             // Channel being served
  output reg  [31:0]              bus_src_addr,         // Source address, zero when ignored
  output reg  [31:0]              bus_dst_addr,         // Destination address, zero when ignored
  output reg  [1:0]               bus_size,             // Access size code
  output reg                      bus_single,           // Single-address item
  output reg                      bus_dir,              // Direction select of the item
  input  wire                     bus_done              // Engine finished the item, one-cycle pulse
);
  // Register window: 0x20 bytes per channel; word 0 source, 1 destination, 2 offset, 3 count,
  // 4 control, 5 status; any other offset reads zero and ignores writes
  localparam ST_IDLE = 3'b001;
  localparam ST_BUSY = 3'b010;
  localparam ST_GAP  = 3'b100;

  reg [31:0]            src_r [0:NCH-1];
  reg [31:0]            dst_r [0:NCH-1];
  reg [31:0]            ofs_r [0:NCH-1];
  reg [31:0]            cnt_r [0:NCH-1];
  reg [`DMAAC_CTL_W-1:0] ctl_r [0:NCH-1];
  reg [2:0]             state_r;
  reg [1:0]             cur_r;
  reg [1:0]             gap_r;
  reg                   last_r;
  reg [31:0]            rd_val;
  wire [NCH-1:0]        req_s;
  wire [NCH-1:0]        wants;
  wire [NCH-1:0]        chan_en;
  wire [NCH-1:0]        chan_busy;
  wire [1:0]            pk;
  wire [1:0]            wch;
  wire [1:0]            rch;
  wire [`DMAAC_CTL_W-1:0] pk_ctl;
  wire [31:0]           pk_cnt;
  wire [2:0]            pk_step;
  wire                  pk_last;
  wire                  pk_use_src;
  wire                  pk_use_dst;
  wire [`DMAAC_CTL_W-1:0] cur_ctl;
  wire [31:0]           cur_cnt;
  wire [2:0]            cur_step;
  wire                  cur_free;
  wire                  use_src;
  wire                  use_dst;
  wire [31:0]           src_next;
  wire [31:0]           dst_next;
  wire [31:0]           cnt_next;
  integer               i;

  function [2:0] sz_bytes;
    input [1:0] code;
    begin
      case (code)
        `DMAAC_SZ_BYTE: sz_bytes = 3'h1;
        `DMAAC_SZ_WORD: sz_bytes = 3'h2;
        default:        sz_bytes = 3'h4;
      endcase
    end
  endfunction

  function [1:0] pick_chan;
    input [3:0] w;
    begin
      if (w[0])      pick_chan = 2'h0;
      else if (w[1]) pick_chan = 2'h1;
      else if (w[2]) pick_chan = 2'h2;
      else           pick_chan = 2'h3;
    end
  endfunction

  function reg_hit;
    input [`DMAAC_ADDR_W-1:0] a;
    input [2:0]               idx;
    begin
      reg_hit = (a[7] == 1'b0) && (a[1:0] == 2'h0) && (a[4:2] == idx);
    end
  endfunction

  // Request pins are asynchronous to clk
  dmaac_sync #(
    .W (NCH)
  ) u_req_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d_in  (xfer_req_in),
    .d_out (req_s)
  );

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_want
      // Auto-request channels run without a pin request
      assign chan_en[g] = ctl_r[g][`DMAAC_CTL_EN];
      assign wants[g]   = chan_en[g] & (ctl_r[g][`DMAAC_CTL_AUTO] | req_s[g]);
    end
  endgenerate

  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_busy
      // Busy per channel, so a status read needs no state decode
      assign chan_busy[g] = (state_r == ST_BUSY) && (cur_r == g);
    end
  endgenerate

  assign wch = reg_addr[6:5];
  assign rch = reg_addr[6:5];
  assign pk  = pick_chan(wants);

  assign pk_ctl  = ctl_r[pk];
  assign pk_cnt  = cnt_r[pk];
  assign pk_step = sz_bytes(pk_ctl[`DMAAC_CTL_SZ]);
  // Remainder below the access size also ends the transfer
  assign pk_last = (pk_cnt != `DMAAC_CNT_FREE) && (pk_cnt <= {29'h0, pk_step});
  // Single-address items show zero on the side they do not use
  assign pk_use_src = ~pk_ctl[`DMAAC_CTL_SGL] | ~pk_ctl[`DMAAC_CTL_DIR];
  assign pk_use_dst = ~pk_ctl[`DMAAC_CTL_SGL] | pk_ctl[`DMAAC_CTL_DIR];

  assign cur_ctl  = ctl_r[cur_r];
  assign cur_cnt  = cnt_r[cur_r];
  assign cur_step = sz_bytes(cur_ctl[`DMAAC_CTL_SZ]);
  assign cur_free = (cur_cnt == `DMAAC_CNT_FREE);
  assign use_src  = ~cur_ctl[`DMAAC_CTL_SGL] | ~cur_ctl[`DMAAC_CTL_DIR];
  assign use_dst  = ~cur_ctl[`DMAAC_CTL_SGL] | cur_ctl[`DMAAC_CTL_DIR];
  // Full 32-bit arithmetic, so all ones counts down from the largest size
  assign cnt_next = last_r ? `DMAAC_CNT_FREE : (cur_cnt - {29'h0, cur_step});

  dmaac_addr_step u_src_step (
    .addr   (src_r[cur_r]),
    .offset (ofs_r[cur_r]),
    .mode   (cur_ctl[`DMAAC_CTL_SM]),
    .step   (cur_step),
    .next   (src_next)
  );

  dmaac_addr_step u_dst_step (
    .addr   (dst_r[cur_r]),
    .offset (ofs_r[cur_r]),
    .mode   (cur_ctl[`DMAAC_CTL_DM]),
    .step   (cur_step),
    .next   (dst_next)
  );

  always @(posedge clk) begin
    if (!rst_n) begin
      for (i = 0; i < NCH; i = i + 1) begin
        src_r[i] <= `DMAAC_REG_RST;
        dst_r[i] <= `DMAAC_REG_RST;
        ofs_r[i] <= `DMAAC_REG_RST;
        cnt_r[i] <= `DMAAC_REG_RST;
        ctl_r[i] <= `DMAAC_CTL_RST;
      end
      state_r             <= ST_IDLE;
      cur_r               <= 2'h0;
      gap_r               <= 2'h0;
      last_r              <= 1'b0;
      bus_valid           <= 1'b0;
      bus_chan            <= 2'h0;
      bus_src_addr        <= `DMAAC_REG_RST;
      bus_dst_addr        <= `DMAAC_REG_RST;
      bus_size            <= `DMAAC_SZ_BYTE;
      bus_single          <= 1'b0;
      bus_dir             <= 1'b0;
      single_addr_ack_out <= {NCH{1'b0}};
      xfer_end_out        <= {NCH{1'b0}};
      xfer_end_irq        <= {NCH{1'b0}};
      reg_rdata           <= `DMAAC_REG_RST;
    end else begin
      // Hardware updates come first so a register write in the same cycle overrides them
      case (state_r)
        ST_IDLE: begin
          // Lowest channel wins; its attributes stand on the bus port for the whole item
          if (|wants) begin
            state_r      <= ST_BUSY;
            cur_r        <= pk;
            last_r       <= pk_last;
            bus_valid    <= 1'b1;
            bus_chan     <= pk;
            bus_size     <= pk_ctl[`DMAAC_CTL_SZ];
            bus_single   <= pk_ctl[`DMAAC_CTL_SGL];
            bus_dir      <= pk_ctl[`DMAAC_CTL_DIR];
            bus_src_addr <= pk_use_src ? src_r[pk] : `DMAAC_REG_RST;
            bus_dst_addr <= pk_use_dst ? dst_r[pk] : `DMAAC_REG_RST;
            for (i = 0; i < NCH; i = i + 1) begin
              single_addr_ack_out[i] <= (pk == i) && pk_ctl[`DMAAC_CTL_SGL];
              xfer_end_out[i]        <= (pk == i) && pk_last;
            end
          end
        end
        ST_BUSY: begin
          if (bus_done) begin
            if (use_src)
              src_r[cur_r] <= src_next;
            if (use_dst)
              dst_r[cur_r] <= dst_next;
            if (!cur_free)
              cnt_r[cur_r] <= cnt_next;
            if (last_r)
              ctl_r[cur_r][`DMAAC_CTL_EN] <= 1'b0;
            state_r             <= ST_GAP;
            gap_r               <= `DMAAC_GAP_CYC;
            bus_valid           <= 1'b0;
            single_addr_ack_out <= {NCH{1'b0}};
            xfer_end_out        <= {NCH{1'b0}};
          end
        end
        ST_GAP: begin
          // Lets a peripheral's dropped request pass the synchroniser before re-arbitration
          if (gap_r == 2'h1)
            state_r <= ST_IDLE;
          gap_r <= gap_r - 2'h1;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase

      if (reg_wr) begin
        if (reg_hit(reg_addr, `DMAAC_IDX_SRC))
          src_r[wch] <= reg_wdata;
        if (reg_hit(reg_addr, `DMAAC_IDX_DST))
          dst_r[wch] <= reg_wdata;
        if (reg_hit(reg_addr, `DMAAC_IDX_OFS))
          ofs_r[wch] <= reg_wdata;
        if (reg_hit(reg_addr, `DMAAC_IDX_CNT))
          cnt_r[wch] <= reg_wdata;
        if (reg_hit(reg_addr, `DMAAC_IDX_CTL))
          ctl_r[wch] <= reg_wdata[`DMAAC_CTL_W-1:0];
        if (reg_hit(reg_addr, `DMAAC_IDX_STS) && reg_wdata[`DMAAC_STS_DONE])
          xfer_end_irq[wch] <= 1'b0;
      end

      // Set after clear, so an ending transfer is never lost to a clear
      if ((state_r == ST_BUSY) && bus_done && last_r)
        xfer_end_irq[cur_r] <= 1'b1;

      // Zero outside its one valid cycle, so a stale value never lingers on the port
      if (reg_rd)
        reg_rdata <= rd_val;
      else
        reg_rdata <= `DMAAC_REG_RST;
    end
  end

  always @* begin
    rd_val = `DMAAC_REG_RST;
    if (reg_hit(reg_addr, `DMAAC_IDX_SRC))
      rd_val = src_r[rch];
    if (reg_hit(reg_addr, `DMAAC_IDX_DST))
      rd_val = dst_r[rch];
    if (reg_hit(reg_addr, `DMAAC_IDX_OFS))
      rd_val = ofs_r[rch];
    if (reg_hit(reg_addr, `DMAAC_IDX_CNT))
      rd_val = cnt_r[rch];
    if (reg_hit(reg_addr, `DMAAC_IDX_CTL))
      rd_val = {{(32-`DMAAC_CTL_W){1'b0}}, ctl_r[rch]};
    if (reg_hit(reg_addr, `DMAAC_IDX_STS)) begin
      rd_val[`DMAAC_STS_EN]   = chan_en[rch];
      rd_val[`DMAAC_STS_DONE] = xfer_end_irq[rch];
      rd_val[`DMAAC_STS_BUSY] = chan_busy[rch];
    end
  end
endmodule // dmaac_top

// [tb/dmaac_checker.sv]
// Port assertions for the DMA address/count block.
// Assumes it is bound to dmaac_top; one clock, synchronous reset.
`timescale 1ns/1ps
module dmaac_checker #(
  parameter NCH = 4
) (
  input wire           clk,                  // Clock
  input wire           rst_n,                // Reset, active low
  input wire [7:0]     reg_addr,             // Register address
  input wire [31:0]    reg_wdata,            // Write data
  input wire           reg_wr,               // Write strobe
  input wire           reg_rd,               // Read strobe
  input wire [31:0]    reg_rdata,            // Read data
  input wire [NCH-1:0] xfer_req_in,          // Requests
  input wire [NCH-1:0] single_addr_ack_out,  // Acknowledges
  input wire [NCH-1:0] xfer_end_out,         // Final item marks
  input wire [NCH-1:0] xfer_end_irq,         // End flags
  input wire           bus_valid,            // Item pending
  input wire [1:0]     bus_chan,             // Channel served
  input wire [31:0]    bus_src_addr,         // Source address
  input wire [31:0]    bus_dst_addr,         // Destination address
  input wire [1:0]     bus_size,             // Access size
  input wire           bus_single,           // Single-address item
  input wire           bus_dir,              // Direction select
  input wire           bus_done              // Item finished
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire [NCH-1:0] chan_bit = NCH'(1) << bus_chan;

  property p_ack_cause;
    |single_addr_ack_out |-> bus_valid && bus_single && single_addr_ack_out == chan_bit;
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without single item");
  property p_ack_given;
    bus_valid && bus_single |-> single_addr_ack_out == chan_bit;
  endproperty
  a_ack_given: assert property (p_ack_given) else $error("single item without ack");
  property p_end_cause;
    |xfer_end_out |-> bus_valid && xfer_end_out == chan_bit;
  endproperty
  a_end_cause: assert property (p_end_cause) else $error("end mark off its item");
  property p_irq_set;
    |xfer_end_out && bus_done |=> (xfer_end_irq & $past(xfer_end_out)) == $past(xfer_end_out);
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("end flag not raised");
  property p_irq_cause;
    |(xfer_end_irq & ~$past(xfer_end_irq)) |-> $past(bus_done && |xfer_end_out);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("end flag without final item");
  property p_src_ignored;
    bus_valid && bus_single && bus_dir |-> bus_src_addr == 32'h0;
  endproperty
  a_src_ignored: assert property (p_src_ignored) else $error("source used with dir 1");
  property p_dst_ignored;
    bus_valid && bus_single && !bus_dir |-> bus_dst_addr == 32'h0;
  endproperty
  a_dst_ignored: assert property (p_dst_ignored) else $error("destination used with dir 0");
  property p_item_hold;
    bus_valid && !bus_done |=> bus_valid && $stable(bus_src_addr) && $stable(bus_dst_addr) && $stable(bus_chan);
  endproperty
  a_item_hold: assert property (p_item_hold) else $error("item changed before done");
endmodule // dmaac_checker

bind dmaac_top dmaac_checker #(.NCH(NCH)) chk_u (.*);

// [tb/dmaac_periph.sv]
// Peripheral on the request pins plus a bus engine answering items.
// Assumes bus_valid stays up until bus_done is sampled.
`timescale 1ns/1ps
module dmaac_periph (
  input  wire       clk,        // Clock
  input  wire       rst_n,      // Reset, active low
  input  wire [3:0] want,       // Channels wishing to transfer
  input  wire [3:0] delay,      // Engine wait per item
  input  wire       bus_valid,  // Item pending
  input  wire [3:0] ack,        // Acknowledges seen
  output reg  [3:0] req,        // Request pins
  output reg        done        // Item finished, one cycle
);
  reg [3:0] wait_r;
  always @(posedge clk) begin
    if (!rst_n) begin
      req <= 4'h0;
      done <= 1'b0;
      wait_r <= 4'h0;
    end else begin
      // Dropped while acknowledged so one request yields one item
      req <= want & ~ack;
      done <= bus_valid && !done && wait_r == delay;
      wait_r <= (bus_valid && !done) ? wait_r + 4'h1 : 4'h0;
    end
  end
endmodule // dmaac_periph

// [tb/dmaac_top_test.sv]
// Self-checking bench for the DMA address/count block.
// Assumes dmaac_top with the partner model on pins and engine port.
`timescale 1ns/1ps
`include "dmaac_map.vh"
module dmaac_top_test;
  reg         clk, rst_n, reg_wr, reg_rd, rd_d;
  reg  [7:0]  reg_addr;
  reg  [31:0] reg_wdata;
  reg  [3:0]  want, delay;
  wire [31:0] reg_rdata, src_a, dst_a;
  wire [3:0]  req, ack, end_pin, irq;
  wire [1:0]  chan, size;
  wire        valid, done, single, dir;
  integer     num_errors, n_checks, n_items, k;
  reg  [31:0] exp_q[$];
  reg  [31:0] m_s, m_d, m_o, m_c, m_b;
  reg  [1:0]  m_ch, m_sz, m_sm, m_dm;
  reg         m_sgl, m_dr;

  dmaac_top dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .xfer_req_in(req),
    .single_addr_ack_out(ack), .xfer_end_out(end_pin), .xfer_end_irq(irq), .bus_valid(valid),
    .bus_chan(chan), .bus_src_addr(src_a), .bus_dst_addr(dst_a), .bus_size(size),
    .bus_single(single), .bus_dir(dir), .bus_done(done));
  dmaac_periph peer_u (.clk(clk), .rst_n(rst_n), .want(want), .delay(delay),
    .bus_valid(valid), .ack(ack), .req(req), .done(done));

  task automatic chk(input [31:0] seen, input [31:0] exp, input [8*12-1:0] what);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("BAD %0s exp %h seen %h", what, exp, seen);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input [7:0] a, input [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  function [31:0] nxt(input [31:0] a, input [1:0] m, input [31:0] o, input [31:0] b);
    case (m)
      `DMAAC_AM_FIX: nxt = a;
      `DMAAC_AM_OFS: nxt = a + o;
      `DMAAC_AM_INC: nxt = a + b;
      default: nxt = a - b;
    endcase
  endfunction
  // Programs one channel, lets it run to its end or stops it after three items, then reads back
  task run(input [1:0] ch, input sgl, input dr, input pin, input [1:0] sz, input [1:0] sm,
           input [1:0] dm, input [31:0] cnt, input stop);
    reg [7:0]  base;
    integer    n0, j;
    base = {1'b0, ch, 5'h0};
    {m_ch, m_sgl, m_dr, m_sz, m_sm, m_dm, m_c} = {ch, sgl, dr, sz, sm, dm, cnt};
    m_s = $urandom;
    m_d = $urandom;
    m_o = $urandom;
    m_b = sz == `DMAAC_SZ_BYTE ? 32'h1 : sz == `DMAAC_SZ_WORD ? 32'h2 : 32'h4;
    n0 = n_items;
    delay <= 4'($urandom_range(3));
    wr(base, m_s);
    wr(base + 8'h04, m_d);
    wr(base + 8'h08, m_o);
    wr(base + 8'h0c, cnt);
    wr(base + 8'h10, {22'h0, dm, sm, sz, !pin, dr, sgl, 1'b1});
    if (pin) want[ch] <= 1'b1;
    for (j = 0; j < 400 && (stop ? n_items < n0 + 3 : irq[ch] !== 1'b1); j++) @(posedge clk);
    if (stop) wr(base + 8'h10, 32'h0);
    want <= 4'h0;
    repeat (12) @(posedge clk);
    if (stop) chk(n_items - n0 >= 3, 1'b1, "items");
    chk(irq[ch], !stop, "end_irq");
    rd(base + 8'h14, {30'h0, !stop, 1'b0});
    wr(base + 8'h14, 32'h2);
    @(negedge clk) chk(irq[ch], 1'b0, "end_irq_clr");
    rd(base, m_s);
    rd(base + 8'h04, m_d);
    rd(base + 8'h08, m_o);
    rd(base + 8'h0c, m_c);
    rd(base + 8'h10, stop ? 32'h0 : {22'h0, dm, sm, sz, !pin, dr, sgl, 1'b0});
    $display("run on channel %0d done, %0d items", ch, n_items - n0);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clk) rd_d <= reg_rd;
  // Each item is compared while bus_done stands, then the model moves on as the design will
  always @(negedge clk) if (valid && done) begin
    n_items = n_items + 1;
    chk(chan, m_ch, "bus_chan");
    chk(size, m_sz, "bus_size");
    chk(src_a, (m_sgl && m_dr) ? 32'h0 : m_s, "bus_src");
    chk(dst_a, (m_sgl && !m_dr) ? 32'h0 : m_d, "bus_dst");
    chk(ack, m_sgl ? 32'h1 << m_ch : 32'h0, "ack");
    chk(end_pin, (m_c != 32'h0 && m_c <= m_b) ? 32'h1 << m_ch : 32'h0, "end_out");
    if (!(m_sgl && m_dr)) m_s = nxt(m_s, m_sm, m_o, m_b);
    if (!(m_sgl && !m_dr)) m_d = nxt(m_d, m_dm, m_o, m_b);
    m_c = (m_c == 32'h0) ? m_c : (m_c <= m_b) ? 32'h0 : m_c - m_b;
  end
  always @(negedge clk) if (rd_d) chk(reg_rdata, exp_q.pop_front(), "reg_rdata");

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #300000;
    num_errors = num_errors + 1;
    end_of_test;
  end
  initial begin
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, want, delay} = 0;
    {num_errors, n_checks, n_items} = 0;
    void'($urandom(32'h10ee88d5));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (k = 0; k < 16; k++) rd({1'b0, k[3:2], 1'b0, k[1:0], 2'h0}, 32'h0);
    wr(8'h80, $urandom);
    rd(8'h80, 32'h0);
    rd(8'h1c, 32'h0);
    $display("reset and map test done");
    run(2'h0, 1'b0, 1'b0, 1'b0, `DMAAC_SZ_BYTE, `DMAAC_AM_INC, `DMAAC_AM_OFS, 32'h2, 1'b0);
    run(2'h1, 1'b1, 1'b1, 1'b1, `DMAAC_SZ_LONG, `DMAAC_AM_INC, `DMAAC_AM_INC, 32'h8, 1'b0);
    run(2'h2, 1'b1, 1'b0, 1'b1, `DMAAC_SZ_WORD, `DMAAC_AM_DEC, `DMAAC_AM_DEC, 32'h5, 1'b0);
    run(2'h3, 1'b0, 1'b0, 1'b0, `DMAAC_SZ_LONG, `DMAAC_AM_DEC, `DMAAC_AM_OFS, 32'h1, 1'b0);
    run(2'h0, 1'b0, 1'b0, 1'b0, `DMAAC_SZ_WORD, `DMAAC_AM_DEC, `DMAAC_AM_FIX, 32'h0, 1'b1);
    run(2'h1, 1'b0, 1'b0, 1'b0, `DMAAC_SZ_LONG, `DMAAC_AM_INC, `DMAAC_AM_FIX, 32'hffffffff, 1'b1);
    repeat (10) @(posedge clk);
    end_of_test;
  end
endmodule // dmaac_top_test
